/* verilog/ssp_top.sv */
`timescale 1ns/10ps
module ssp_top
  import ssp_pkg::*;
(
  // system
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial pins
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE_N,
  input  wire logic        SERIAL_IN_PIN,
  output logic             SERIAL_OUT_PIN,
  output logic             SERIAL_OUT_OE_N,
  input  wire logic        SS_N,
  // timer and event
  input  wire logic        TIMER_TWO_TICK,
  output logic             PORT_IRQ_FLAG
);
  // ***********************************************
  // registers
  // ***********************************************
  ssp_state_t  state_ff;
  logic [7:0]  ctl_ff;
  logic [7:0]  buf_ff;
  logic        bf_ff;
  logic        irq_ff;
  logic [5:0]  hcnt_ff;
  logic [2:0]  pcnt_ff;
  logic        sck_ff;
  logic        m_smp_ff;
  logic        sck_d_ff;
  logic        sck_oe_n_ff;
  logic        sdo_oe_n_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [2:0]  pins_s;
  ssp_shift_if sif ();
  // ***********************************************
  // pin synchronisers and shifter
  // ***********************************************
  ssp_sync #(.W(3)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({SCK_I, SERIAL_IN_PIN, SS_N}),
    .q   (pins_s)
  );
  ssp_shifter u_shift (
    .clk (CLK),
    .rst (RST),
    .sif (sif)
  );
  wire sck_s  = pins_s[2];
  wire sdi_s  = pins_s[1];
  wire ss_n_s = pins_s[0];
  // ***********************************************
  // mode decode
  // ***********************************************
  wire [3:0] mode      = ctl_ff[3:0];
  wire       en        = ctl_ff[BIT_EN]; // [R11] [R12]
  wire       clock_polarity_bit       = ctl_ff[BIT_CKP];
  wire       is_master = en && (mode <= MODE_MST_TIMER_TWO); // [R15]
  wire       is_slv_ss = en && (mode == MODE_SLV_SS); // [R16]
  wire       is_slv_no = en && (mode == MODE_SLV_NOSS); // [R16]
  wire       is_slave  = is_slv_ss || is_slv_no; // [R17]
  wire       slave_go  = is_slv_no || (is_slv_ss && !ss_n_s); // [R19] [R20]
  wire       running   = (state_ff == ST_RUN);
  wire       busy      = running || sif.busy;
  // ***********************************************
  // apb decode
  // ***********************************************
  wire access  = PSEL && PENABLE && pready_ff;
  wire setup   = PSEL && !PENABLE;
  wire sel_buf = (PADDR == ADDR_XFER_BUFFER);
  wire sel_ctl = (PADDR == ADDR_PORT_CONTROL);
  wire sel_sta = (PADDR == ADDR_PORT_STATUS);
  wire sel_evt = (PADDR == ADDR_PORT_EVENT);
  wire mapped  = sel_buf || sel_ctl || sel_sta || sel_evt;
  wire wr      = access && PWRITE && mapped;
  wire wr_buf  = wr && sel_buf;
  wire wr_ctl  = wr && sel_ctl;
  wire wr_evt  = wr && sel_evt;
  wire rd_buf  = access && !PWRITE && sel_buf;
  wire buf_ok  = wr_buf && !busy; // [R5]
  wire [31:0] rd_val = sel_buf ? {24'h0000_00, buf_ff} :
                       sel_ctl ? {24'h0000_00, ctl_ff} :
                       sel_sta ? {31'h0000_0000, bf_ff} :
                       sel_evt ? {31'h0000_0000, irq_ff} : 32'h0000_0000;
  // ***********************************************
  // master clock generator
  // ***********************************************
  wire [5:0] half = (mode == MODE_MST_DIV4)  ? HALF_FAST :
                    (mode == MODE_MST_DIV16) ? HALF_MID : HALF_SLOW; // [R15]
  wire m_tick   = running && ((mode == MODE_MST_TIMER_TWO) ? TIMER_TWO_TICK : (hcnt_ff == half)); // [R15]
  wire m_change = m_tick && (sck_ff == clock_polarity_bit);
  wire m_sample = m_tick && (sck_ff != clock_polarity_bit);
  wire m_last   = m_sample && (pcnt_ff == LAST_BIT); // [R21]
  // ***********************************************
  // slave edge detect
  // ***********************************************
  wire s_edge   = slave_go && (sck_s != sck_d_ff);
  wire s_change = s_edge && (sck_s != clock_polarity_bit); // [R13] [R14]
  wire s_sample = s_edge && (sck_s == clock_polarity_bit); // [R13] [R14]
  // ***********************************************
  // shifter control
  // ***********************************************
  assign sif.clear     = !is_master && !is_slave;
  assign sif.load      = buf_ok; // [R10]
  assign sif.load_data = PWDATA[7:0];
  assign sif.change    = m_change || s_change;
  // master samples one cycle after its trailing edge: data in lags the pin by the synchroniser
  assign sif.sample    = (m_smp_ff && is_master) || s_sample; // [R13] [R14]
  assign sif.sdi_bit   = sdi_s;
  wire cpl      = sif.done;
  wire overflow = cpl && is_slave && bf_ff && !rd_buf; // [R7] [R8]
  // ***********************************************
  // state and clock
  // ***********************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_IDLE;
      hcnt_ff  <= 6'h00;
      pcnt_ff  <= 3'h0;
      sck_ff   <= 1'b0;
      m_smp_ff <= 1'b0;
    end else begin
      m_smp_ff <= m_sample;
      case (state_ff)
        ST_IDLE: begin
          hcnt_ff <= 6'h00;
          pcnt_ff <= 3'h0;
          sck_ff  <= clock_polarity_bit; // [R13] [R14]
          if (buf_ok && is_master) begin
            state_ff <= ST_RUN; // [R10]
          end
        end
        ST_RUN: begin
          hcnt_ff <= m_tick ? 6'h00 : hcnt_ff + 6'h01;
          if (m_tick) begin
            sck_ff <= ~sck_ff;
          end
          if (m_sample) begin
            pcnt_ff <= pcnt_ff + 3'h1;
          end
          if (m_last || !is_master) begin
            state_ff <= ST_IDLE; // [R21]
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  // ***********************************************
  // control, buffer and flags
  // ***********************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_ff <= CONTROL_RESET; // [R22]
      buf_ff <= 8'h00;
      bf_ff  <= 1'b0; // [R22]
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_ff <= PWDATA[7:0]; // [R6] [R9]
      end
      if (wr_buf && busy) begin
        ctl_ff[BIT_WRITE_COLLISION_FLAG] <= 1'b1; // [R5]
      end
      if (overflow) begin
        ctl_ff[BIT_OVF] <= 1'b1; // [R7]
      end
      if (rd_buf) begin
        bf_ff <= 1'b0; // [R4]
      end
      if (wr_evt && PWDATA[BIT_IRQ]) begin
        irq_ff <= 1'b0;
      end
      if (cpl && !overflow) begin
        buf_ff <= sif.data; // [R3] [R4]
        bf_ff  <= 1'b1; // [R3]
        irq_ff <= 1'b1; // [R3]
      end
    end
  end
  // ***********************************************
  // pins and bus outputs
  // ***********************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_d_ff    <= 1'b0;
      sck_oe_n_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
      prdata_ff   <= 32'h0000_0000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
    end else begin
      sck_d_ff    <= sck_s;
      sck_oe_n_ff <= !is_master; // [R11] [R12]
      sdo_oe_n_ff <= !(is_master || slave_go); // [R19] [R20]
      pready_ff   <= setup;
      if (setup) begin
        prdata_ff  <= rd_val;
        pslverr_ff <= !(sel_buf || sel_ctl || sel_sta || sel_evt);
      end
    end
  end
  assign SCK_O           = sck_ff;
  assign SCK_OE_N        = sck_oe_n_ff;
  assign SERIAL_OUT_PIN  = sif.sdo_bit;
  assign SERIAL_OUT_OE_N = sdo_oe_n_ff;
  assign PRDATA          = prdata_ff;
  assign PREADY          = pready_ff;
  assign PSLVERR         = pslverr_ff;
  assign PORT_IRQ_FLAG   = irq_ff;
  // ***********************************************
  // checks
  // ***********************************************
  AST_BF_SET: assert property (@(posedge CLK) disable iff (RST) // [R3]
    (cpl && !overflow) |=> (bf_ff && irq_ff && buf_ff == $past(sif.data)))
    else $error("completed byte not stored");
  AST_READ_CLR: assert property (@(posedge CLK) disable iff (RST) // [R4]
    (rd_buf && !cpl) |=> !bf_ff)
    else $error("buffer read did not clear full bit");
  AST_WRITE_COLLISION_FLAG: assert property (@(posedge CLK) disable iff (RST) // [R5]
    (wr_buf && busy) |=> (ctl_ff[BIT_WRITE_COLLISION_FLAG] &&
      (sif.data == $past(sif.data) || sif.data == {$past(sif.data[6:0]), $past(sif.sdi_bit)})))
    else $error("busy write not flagged or not dropped");
  AST_OVF_LOST: assert property (@(posedge CLK) disable iff (RST) // [R7]
    overflow |=> (ctl_ff[BIT_OVF] && $stable(buf_ff) && bf_ff))
    else $error("overflow not flagged or buffer overwritten");
  AST_OVF_SLAVE: assert property (@(posedge CLK) disable iff (RST) // [R8]
    (!$past(ctl_ff[BIT_OVF]) && ctl_ff[BIT_OVF]) |-> ($past(is_slave) || $past(wr_ctl)))
    else $error("overflow set outside slave operation");
  AST_START: assert property (@(posedge CLK) disable iff (RST) // [R10]
    (buf_ok && is_master && mode != MODE_MST_TIMER_TWO) |=> running ##[1:32] (sck_ff != clock_polarity_bit))
    else $error("master write did not start a transfer");
  AST_DISABLE: assert property (@(posedge CLK) disable iff (RST) // [R12]
    !en |=> (SCK_OE_N && SERIAL_OUT_OE_N))
    else $error("pins not released while disabled");
  AST_IDLE_HIGH: assert property (@(posedge CLK) disable iff (RST) // [R13]
    (!running && $past(!running) && clock_polarity_bit && $past(clock_polarity_bit)) |-> SCK_O)
    else $error("clock not idle high");
  AST_IDLE_LOW: assert property (@(posedge CLK) disable iff (RST) // [R14]
    (!running && $past(!running) && !clock_polarity_bit && $past(!clock_polarity_bit)) |-> !SCK_O)
    else $error("clock not idle low");
  AST_SS_REL: assert property (@(posedge CLK) disable iff (RST) // [R20]
    (is_slv_ss && ss_n_s) |=> SERIAL_OUT_OE_N)
    else $error("output driven while select high");
  AST_EIGHT: assert property (@(posedge CLK) disable iff (RST) // [R21]
    m_last |=> (!running && pcnt_ff == 3'h0))
    else $error("master did not stop after eight pulses");
endmodule // ssp_top

/* verilog/ssp_pkg.sv */
// How it works
// [R1] shift eight bits out and in together
// [R2] shift register moves msb first
// [R3] full byte copies to buffer, sets flags
// [R4] buffer read clears full; next byte overlaps
// [R5] buffer write while busy dropped, collision set
// [R6] software clears the collision flag
// [R7] slave overflow keeps old buffer, sets flag
// [R8] overflow never set in master operation
// [R9] software clears overflow and reads every byte
// [R10] master buffer write starts a transfer
// [R11] enable bit hands pins to the port
// [R12] cleared enable releases pins to general use
// [R13] polarity one: idle high, sample rising
// [R14] polarity zero: idle low, sample falling
// [R15] master codes pick the four clock rates
// [R16] slave codes with and without select
// [R17] two-wire codes leave this port idle
// [R18] software reads buffer before next write
// [R19] select low enables slave and drives out
// [R20] select high releases out, transfer resumes
// [R21] master gives eight clock pulses, then idles
// [R22] flags clear on reset
package ssp_pkg;
  // ***********************************************
  // register map (index, byte address = 4 x index)
  // ***********************************************
  localparam logic [11:0] IDX_XFER_BUFFER  = 12'h0013;
  localparam logic [11:0] IDX_PORT_CONTROL = 12'h0014;
  localparam logic [11:0] IDX_PORT_STATUS  = 12'h0094;
  localparam logic [11:0] IDX_PORT_EVENT   = 12'h0020;
  localparam logic [11:0] ADDR_XFER_BUFFER  = 12'(IDX_XFER_BUFFER * 4);
  localparam logic [11:0] ADDR_PORT_CONTROL = 12'(IDX_PORT_CONTROL * 4);
  localparam logic [11:0] ADDR_PORT_STATUS  = 12'(IDX_PORT_STATUS * 4);
  localparam logic [11:0] ADDR_PORT_EVENT   = 12'(IDX_PORT_EVENT * 4);
  // ***********************************************
  // fields
  // ***********************************************
  localparam int BIT_WRITE_COLLISION_FLAG = 7;
  localparam int BIT_OVF  = 6;
  localparam int BIT_EN   = 5;
  localparam int BIT_CKP  = 4;
  localparam int BIT_BF   = 0;
  localparam int BIT_IRQ  = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MST_TIMER_TWO  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS    = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;
  // ***********************************************
  // timing: serial clock period in system clocks
  // ***********************************************
  localparam int DIV_FAST = 4;
  localparam int DIV_MID  = 16;
  localparam int DIV_SLOW = 64;
  localparam logic [5:0] HALF_FAST = 6'(DIV_FAST / 2 - 1);
  localparam logic [5:0] HALF_MID  = 6'(DIV_MID / 2 - 1);
  localparam logic [5:0] HALF_SLOW = 6'(DIV_SLOW / 2 - 1);
  localparam logic [2:0] LAST_BIT  = 3'h7;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} ssp_state_t;
endpackage

/* verilog/ssp_shift_if.sv */
`timescale 1ns/10ps
interface ssp_shift_if;
  logic       clear;
  logic       load;
  logic [7:0] load_data;
  logic       change;
  logic       sample;
  logic       sdi_bit;
  logic [7:0] data;
  logic       sdo_bit;
  logic       done;
  logic       busy;
  modport shifter (input clear, load, load_data, change, sample, sdi_bit, output data, sdo_bit, done, busy);
  modport ctrl (output clear, load, load_data, change, sample, sdi_bit, input data, sdo_bit, done, busy);
endinterface

/* verilog/ssp_sync.sv */
`timescale 1ns/10ps
module ssp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // ssp_sync

/* verilog/ssp_shifter.sv */
`timescale 1ns/10ps
module ssp_shifter
  import ssp_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst,
  ssp_shift_if.shifter sif
);
  logic [7:0] sr_ff;
  logic [2:0] cnt_ff;
  logic       sdo_ff;
  logic       done_ff;
  logic       busy_ff;
  assign sif.data    = sr_ff;
  assign sif.sdo_bit = sdo_ff;
  assign sif.done    = done_ff;
  assign sif.busy    = busy_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_ff   <= 8'h00;
      cnt_ff  <= 3'h0;
      sdo_ff  <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (sif.clear) begin
        cnt_ff  <= 3'h0;
        busy_ff <= 1'b0;
      end else if (sif.load) begin
        sr_ff  <= sif.load_data;
        cnt_ff <= 3'h0;
        sdo_ff <= sif.load_data[7]; // [R2]
      end else begin
        if (sif.change) begin
          sdo_ff  <= sr_ff[7]; // [R2]
          busy_ff <= 1'b1;
        end
        if (sif.sample) begin
          sr_ff  <= {sr_ff[6:0], sif.sdi_bit}; // [R1] [R2]
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == LAST_BIT) begin
            done_ff <= 1'b1; // [R1]
            busy_ff <= 1'b0;
          end
        end
      end
    end
  end
endmodule // ssp_shifter

/* verif/ssp_far_model.sv */
`timescale 1ns/10ps
module ssp_far_model (
  // link
  input  wire logic       cpol,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // user side
  output logic      [7:0] rx,
  output int              edges
);
  logic [7:0] sh;
  initial begin
    sh    = 8'h00;
    miso  = 1'b0;
    rx    = 8'h00;
    edges = 0;
  end
  task automatic arm(input logic [7:0] tx);
    sh    = tx;
    edges = 0;
  endtask
  // new bit on the leading edge, latch on the trailing edge, msb first
  always @(sck) begin
    if (sck !== cpol) begin
      miso = sh[7];
      edges++;
    end else begin
      sh = {sh[6:0], mosi};
      rx = sh;
    end
  end
endmodule // ssp_far_model

/* verif/ssp_top_tb_top.sv */
`timescale 1ns/10ps
module ssp_top_tb_top
  import ssp_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, sck_m, ss_n, tick, cpol, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, sck_o, sck_oe_n, sin, sout, sout_oe_n, irq;
  logic [7:0]  rx, b, t;
  logic [3:0]  tw [5] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  wire         sck_w  = sck_oe_n ? sck_m : sck_o;
  wire         mosi_w = sout_oe_n ? 1'b1 : sout;
  int          fails, cmp_count, edges;
  int          tdiv = 0;
  ssp_top i_ssp_top (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE_N(sck_oe_n), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout), .SERIAL_OUT_OE_N(sout_oe_n),
    .SS_N(ss_n), .TIMER_TWO_TICK(tick), .PORT_IRQ_FLAG(irq));
  ssp_far_model i_ssp_far_model (.cpol(cpol), .sck(sck_w), .mosi(mosi_w), .miso(sin), .rx(rx), .edges(edges));
  // ******************************
  // bus and check tasks
  // ******************************
  always #10 clk = ~clk;
  // timer output: regular one-cycle pulse every eighth clock
  always @(posedge clk) begin
    tdiv <= (tdiv == 7) ? 0 : tdiv + 1;
    tick <= (tdiv == 7);
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      #80 sck_m = ~sck_m;
      #80 sck_m = ~sck_m;
    end
    repeat (10) @(posedge clk);
  endtask
  initial begin
    #400000;
    fails++;
    close_out();
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sck_m = 0; ss_n = 1; tick = 0; cpol = 0;
    void'($urandom(32'h42c5_9fa2));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, ADDR_PORT_CONTROL, 0); chk("ctrl_rst", 0, r);
    apb(0, ADDR_PORT_STATUS, 0); chk("stat_rst", 0, r);
    apb(0, 12'h004, 0); chk("unmapped", 32'h0000_0001, {r[30:0], err});
    for (int m = 0; m < 4; m++) begin
      cpol = 1'($urandom_range(1, 0)); sck_m = cpol; b = 8'($urandom); t = 8'($urandom);
      apb(1, ADDR_PORT_CONTROL, 32'({3'b001, cpol, 4'(m)}));
      repeat (4) @(posedge clk);
      chk("sck_oe", 0, 32'(sck_oe_n));
      i_ssp_far_model.arm(t);
      apb(1, ADDR_XFER_BUFFER, 32'(b));
      apb(1, ADDR_XFER_BUFFER, 32'(~b));
      r = 32'h0000_0000;
      for (int i = 0; i < 400 && r[0] !== 1'b1; i++) apb(0, ADDR_PORT_STATUS, 0);
      chk("sck_idle", 32'(cpol), 32'(sck_o));
      chk("pulses", 8, edges);
      chk("far_rx", 32'(b), 32'(rx));
      chk("irq", 1, 32'(irq));
      apb(0, ADDR_PORT_CONTROL, 0); chk("ctrl_write_collision_flag", 32'({3'b101, cpol, 4'(m)}), r);
      apb(0, ADDR_XFER_BUFFER, 0); chk("rx_byte", 32'(t), r);
      apb(0, ADDR_PORT_STATUS, 0); chk("full_clr", 0, r);
      apb(1, ADDR_PORT_EVENT, 1);
      apb(1, ADDR_PORT_CONTROL, 0);
    end
    cpol = 0; sck_m = 0;
    apb(1, ADDR_PORT_CONTROL, 32'h0000_0025);
    repeat (4) @(posedge clk);
    t = 8'($urandom); b = 8'($urandom);
    i_ssp_far_model.arm(t);
    apb(1, ADDR_XFER_BUFFER, 32'(b));
    pulses(8);
    chk("slv_tx", 32'(b), 32'(rx));
    i_ssp_far_model.arm(~t);
    pulses(8);
    apb(0, ADDR_PORT_CONTROL, 0); chk("ovf", 32'h0000_0065, r);
    apb(0, ADDR_XFER_BUFFER, 0); chk("ovf_keep", 32'(t), r);
    apb(1, ADDR_PORT_CONTROL, 0);
    cpol = 1; sck_m = 1;
    apb(1, ADDR_PORT_CONTROL, 32'h0000_0034);
    @(posedge clk) ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    t = 8'($urandom); b = 8'($urandom);
    i_ssp_far_model.arm(t);
    apb(1, ADDR_XFER_BUFFER, 32'(b));
    pulses(4);
    chk("ss_drive", 0, 32'(sout_oe_n));
    @(posedge clk) ss_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ss_float", 1, 32'(sout_oe_n));
    @(posedge clk) ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    pulses(4);
    chk("ss_resume", 32'(b), 32'(rx));
    apb(0, ADDR_XFER_BUFFER, 0); chk("ss_rx", 32'(t), r);
    foreach (tw[i]) begin
      apb(1, ADDR_PORT_CONTROL, 32'({4'h2, tw[i]}));
      repeat (4) @(posedge clk);
      chk("two_wire", 3, 32'({sck_oe_n, sout_oe_n}));
    end
    apb(1, ADDR_PORT_CONTROL, 32'h0000_0010);
    repeat (4) @(posedge clk);
    chk("disabled", 3, 32'({sck_oe_n, sout_oe_n}));
    close_out();
  end
endmodule // ssp_top_tb_top
